//--- design/flash_cmd_defs.vh
// opcodes, status field layouts and timing counts for the
// flash status / extended-address command block.
// assumes a 200 MHz ref_clk; included by bare name.
`ifndef FLASH_CMD_DEFS_VH
`define FLASH_CMD_DEFS_VH

// ---------------------------------------------------------------
// opcodes
// ---------------------------------------------------------------
`define OP_WREN      8'h06
`define OP_WRDI      8'h04
`define OP_VWREN     8'h50
`define OP_RDS1      8'h05
`define OP_RDS2      8'h35
`define OP_RDS3      8'h15
`define OP_WRS1      8'h01
`define OP_WRS2      8'h31
`define OP_WRS3      8'h11
`define OP_RDEXT     8'hc8
`define OP_WREXT     8'hc5
`define OP_EN4B      8'hb7
`define OP_EX4B      8'he9
`define OP_READ      8'h03

// ---------------------------------------------------------------
// status byte fields
// ---------------------------------------------------------------
// byte one: [7] srp_zero_protect [6] top/bottom [5:2] block protect [1] wel [0] busy
`define S1_WR_MASK   8'hfc
`define S1_WEL_BIT   1
`define S1_BUSY_BIT  0
// byte two: [6] complement [5:3] lock bits [1] quad enable [0] srp_one_protect
`define S2_WR_MASK   8'h7b
`define S2_LB_MASK   8'h38
`define S2_QE_MASK   8'h02
`define S2_SRP_ONE_PROTECT_MASK 8'h01
// byte three: [7] pin function [6:5] strength [2] scheme [1] addr dflt
`define S3_WR_MASK   8'he6
`define S3_ADP_BIT   1
`define S3_ADS_BIT   0

// ---------------------------------------------------------------
// bit counts and timing
// ---------------------------------------------------------------
`define CNT_BYTE     6'd8
`define CNT_ADDR3    6'd24
`define CNT_ADDR4    6'd32
`define CLK_PERIOD_PS    5000
`define SW_TIME_NS       1000000
`define SW_CYCLES ((`SW_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define VREFRESH_TIME_NS 50
`define VREFRESH_CYCLES  ((`VREFRESH_TIME_NS * 1000) / `CLK_PERIOD_PS)

`endif

//--- design/flash_status_addr_cmds.v
// status, extended-address and read command handling
// of a serial flash, oversampling the spi pins with ref_clk.
// assumes serial_clock half periods of at least 3 ref_clk cycles and
// an array whose mem_rdata is valid the cycle after mem_addr changes.
//
// Summary of operation
// - opcodes 05h, 35h, 15h read status byte one, two, three.
// - opcode sampled on rising edges; status shifted out msb first on falls.
// - status reads are accepted any time, even during a busy cycle.
// - status byte repeats while clocks run; chip select high ends it.
// - status writes touch writable fields only; lock bits stay set once set.
// - non-volatile write needs 06h first; refused when the latch is clear.
// - after 50h, write volatile copies only; srp_one_protect and lock bits never clear.
// - soft reset reloads the live status fields from non-volatile copies; arst_n clears both.
// - non-volatile write starts timed busy cycle; latch clears at its end.
// - volatile write applies promptly at chip select rise, busy stays low.
// - quad enable cannot be written while in quad command mode.
// - 01h with sixteen data bits writes bytes one and two; eight only one.
// - opcode C8h shifts the extended-address byte out msb first.
// - 3-byte mode uses extended byte as a31..a24; 4-byte mode ignores it.
// - C5h loads the extended-address byte only when the latch is set.
// - power-up and resets clear the extended-address byte to zero.
// - in 4-byte mode addressed commands overwrite extended byte with a31..a24.
// - B7h enters 32-bit addressing, E9h returns to 24-bit addressing.
// - 03h takes 24 or 32 address bits, then returns data msb first.
// - read address increments after each byte until chip select rises.
// - read ignored while busy; 03h honoured only in single-wire mode.
`timescale 1ns/1ps
`include "flash_cmd_defs.vh"

module flash_status_addr_cmds #(
   parameter [31:0] STATUS_WRITE_CYCLES = `SW_CYCLES
) (
   input wire ref_clk,
   input wire arst_n,
   input wire soft_reset,
   input wire chip_select_n,
   input wire serial_clock,
   input wire [3:0] io_in,
   output reg [3:0] io_out,
   output reg [3:0] io_oe_n,
   input wire quad_command_mode,
   input wire array_busy,
   output reg [31:0] mem_addr,
   output reg mem_rd,
   input wire [7:0] mem_rdata,
   output reg status_write_busy,
   output reg write_enable_latch,
   output reg address_width_select,
   output reg [7:0] status_one_cfg,
   output reg [7:0] status_two_cfg,
   output reg [7:0] status_three_cfg,
   output reg [7:0] upper_address_byte
);

   // ---------------------------------------------------------------
   // states
   // ---------------------------------------------------------------
   localparam [4:0] ST_OPC = 5'b00001;
   localparam [4:0] ST_ADDR = 5'b00010;
   localparam [4:0] ST_DIN = 5'b00100;
   localparam [4:0] ST_DOUT = 5'b01000;
   localparam [4:0] ST_SKIP = 5'b10000;

   wire [5:0] pins_s;
   reg cs_q;
   reg sck_q;
   reg [4:0] state;
   reg [7:0] cmd;
   reg cmd_ok;
   reg [31:0] in_sh;
   reg [5:0] cnt;
   reg [1:0] byte_cnt;
   reg [7:0] data0;
   reg [7:0] data1;
   reg [7:0] out_sh;
   reg [2:0] out_cnt;
   reg vol_en;
   reg [31:0] sw_cnt;
   reg [7:0] nv_one;
   reg [7:0] nv_two;
   reg [7:0] nv_three;
   reg [7:0] next_one;
   reg [7:0] next_two;
   reg [7:0] next_three;
   reg [7:0] src_byte;
   reg [7:0] out_byte;
   reg [31:0] next_addr;
   reg do_one;
   reg do_two;
   reg do_three;

   // ---------------------------------------------------------------
   // pin synchronisation and edge detection
   // ---------------------------------------------------------------
   sync_2ff #(.WIDTH(6)) u_sync (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .d({chip_select_n, serial_clock, io_in}),
      .q(pins_s)
   );

   wire cs_s = pins_s[5];
   wire sck_s = pins_s[4];
   wire [3:0] io_s = pins_s[3:0];
   wire cs_rise = cs_s & ~cs_q;
   wire sck_rise = sck_s & ~sck_q & ~cs_s;
   wire sck_fall = ~sck_s & sck_q & ~cs_s;
   wire busy = array_busy | status_write_busy;
   wire [5:0] step = quad_command_mode ? 6'd4 : 6'd1;
   wire [5:0] next_cnt = cnt + step;
   // quad: io3..io0 per clock, msb nibble first
   wire [31:0] next_sh = quad_command_mode ? {in_sh[27:0], io_s} :
      {in_sh[30:0], io_s[0]};
   wire [5:0] addr_len = address_width_select ? `CNT_ADDR4 : `CNT_ADDR3;
   wire is_status_rd = (next_sh[7:0] == `OP_RDS1) ||
      (next_sh[7:0] == `OP_RDS2) || (next_sh[7:0] == `OP_RDS3);

   // ---------------------------------------------------------------
   // merged status values for a pending write
   // ---------------------------------------------------------------
   // base: live copy if volatile, else stored copy
   always @*
   begin
      next_one = vol_en ? status_one_cfg : nv_one;
      next_two = vol_en ? status_two_cfg : nv_two;
      next_three = vol_en ? status_three_cfg : nv_three;
      do_one = (cmd == `OP_WRS1);
      do_two = (cmd == `OP_WRS2) ||
         ((cmd == `OP_WRS1) && (byte_cnt == 2'd2));
      do_three = (cmd == `OP_WRS3);
      // only writable fields move
      next_one = (next_one & ~`S1_WR_MASK) |
         (data0 & `S1_WR_MASK);
      if (cmd == `OP_WRS1)
      begin
         next_two = (next_two & ~`S2_WR_MASK) | (data1 & `S2_WR_MASK);
      end
      else
      begin
         next_two = (next_two & ~`S2_WR_MASK) | (data0 & `S2_WR_MASK);
      end
      // lock bits stay set once set
      next_two = next_two | (nv_two & `S2_LB_MASK) |
         (status_two_cfg & `S2_LB_MASK);
      if (vol_en)
      begin
         next_two = next_two |
            (status_two_cfg & `S2_SRP_ONE_PROTECT_MASK);
      end
      if (quad_command_mode)
      begin
         next_two = (next_two & ~`S2_QE_MASK) |
            (status_two_cfg & `S2_QE_MASK);
      end
      next_three = (next_three & ~`S3_WR_MASK) | (data0 & `S3_WR_MASK);
   end

   // ---------------------------------------------------------------
   // output byte source and address formation
   // ---------------------------------------------------------------
   always @*
   begin
      src_byte = 8'h00;
      if (cmd == `OP_RDS1)
      begin
         // busy and latch are live, so polling sees them change
         src_byte = {status_one_cfg[7:2], write_enable_latch,
            busy};
      end
      else if (cmd == `OP_RDS2)
      begin
         src_byte = status_two_cfg & `S2_WR_MASK;
      end
      else if (cmd == `OP_RDS3)
      begin
         src_byte = (status_three_cfg & `S3_WR_MASK) |
            {7'h00, address_width_select};
      end
      else if (cmd == `OP_RDEXT)
      begin
         src_byte = upper_address_byte;
      end
      else if (cmd == `OP_READ)
      begin
         src_byte = mem_rdata;
      end
      out_byte = (out_cnt == 3'd0) ? src_byte : out_sh;
      if (address_width_select)
      begin
         next_addr = next_sh;
      end
      else
      begin
         next_addr = {upper_address_byte, next_sh[23:0]};
      end
   end

   // ---------------------------------------------------------------
   // command engine
   // ---------------------------------------------------------------
   // one process owns all control state so cs rise, the timer and
   // soft reset are ordered by plain priority
   always @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cs_q <= 1'b1;
         sck_q <= 1'b0;
         state <= ST_OPC;
         cmd <= 8'h00;
         cmd_ok <= 1'b0;
         in_sh <= 32'h0000_0000;
         cnt <= 6'd0;
         byte_cnt <= 2'd0;
         data0 <= 8'h00;
         data1 <= 8'h00;
         out_sh <= 8'h00;
         out_cnt <= 3'd0;
         vol_en <= 1'b0;
         sw_cnt <= 32'h0000_0000;
         nv_one <= 8'h00;
         nv_two <= 8'h00;
         nv_three <= 8'h00;
         io_out <= 4'h0;
         io_oe_n <= 4'hf;
         mem_addr <= 32'h0000_0000;
         mem_rd <= 1'b0;
         status_write_busy <= 1'b0;
         write_enable_latch <= 1'b0;
         address_width_select <= 1'b0;
         status_one_cfg <= 8'h00;
         status_two_cfg <= 8'h00;
         status_three_cfg <= 8'h00;
         upper_address_byte <= 8'h00;
      end
      else
      begin
         cs_q <= cs_s;
         sck_q <= sck_s;
         mem_rd <= 1'b0;
         if (soft_reset)
         begin
            // drop volatile values, reload stored ones
            status_one_cfg <= nv_one;
            status_two_cfg <= nv_two;
            status_three_cfg <= nv_three;
            address_width_select <= nv_three[`S3_ADP_BIT];
            upper_address_byte <= 8'h00;
            write_enable_latch <= 1'b0;
            status_write_busy <= 1'b0;
            vol_en <= 1'b0;
            cmd_ok <= 1'b0;
            state <= ST_OPC;
            cnt <= 6'd0;
            io_oe_n <= 4'hf;
         end
         else
         begin
            // self-timed write cycle
            if (status_write_busy)
            begin
               if (sw_cnt == STATUS_WRITE_CYCLES - 32'd1)
               begin
                  status_write_busy <= 1'b0;
                  write_enable_latch <= 1'b0;
               end
               else
               begin
                  sw_cnt <= sw_cnt + 32'd1;
               end
            end
            if (cs_rise)
            begin
               // select high ends the transfer, frees the pins
               state <= ST_OPC;
               cnt <= 6'd0;
               byte_cnt <= 2'd0;
               io_oe_n <= 4'hf;
               cmd_ok <= 1'b0;
               if (cmd_ok && (cmd != `OP_VWREN) && !is_status_cmd(cmd))
               begin
                  vol_en <= 1'b0;
               end
               if (cmd_ok)
               begin
                  if (cmd == `OP_WREN)
                  begin
                     write_enable_latch <= 1'b1;
                  end
                  else if (cmd == `OP_WRDI)
                  begin
                     write_enable_latch <= 1'b0;
                  end
                  else if (cmd == `OP_VWREN)
                  begin
                     vol_en <= 1'b1;
                  end
                  else if (cmd == `OP_EN4B)
                  begin
                     address_width_select <= 1'b1;
                  end
                  else if (cmd == `OP_EX4B)
                  begin
                     address_width_select <= 1'b0;
                  end
                  else if ((cmd == `OP_WREXT) && (byte_cnt != 2'd0) &&
                     write_enable_latch)
                  begin
                     upper_address_byte <= data0;
                     write_enable_latch <= 1'b0;
                  end
                  else if ((do_one || do_two || do_three) &&
                     (byte_cnt != 2'd0))
                  begin
                     if (vol_en)
                     begin
                        // live copies only
                        if (do_one)
                           status_one_cfg <= next_one;
                        if (do_two)
                           status_two_cfg <= next_two;
                        if (do_three)
                           status_three_cfg <= next_three;
                     end
                     else if (write_enable_latch)
                     begin
                        // refused when the latch is clear
                        status_write_busy <= 1'b1;
                        sw_cnt <= 32'h0000_0000;
                        if (do_one)
                        begin
                           nv_one <= next_one;
                           status_one_cfg <= next_one;
                        end
                        if (do_two)
                        begin
                           nv_two <= next_two;
                           status_two_cfg <= next_two;
                        end
                        if (do_three)
                        begin
                           nv_three <= next_three;
                           status_three_cfg <= next_three;
                        end
                     end
                  end
               end
            end
            else if (sck_rise)
            begin
               // sample on serial clock rise
               in_sh <= next_sh;
               cnt <= next_cnt;
               if (state == ST_OPC)
               begin
                  if (next_cnt == `CNT_BYTE)
                  begin
                     cmd <= next_sh[7:0];
                     cnt <= 6'd0;
                     out_cnt <= 3'd0;
                     cmd_ok <= 1'b1;
                     if (is_status_rd)
                     begin
                        state <= ST_DOUT;
                     end
                     else if (busy)
                     begin
                        state <= ST_SKIP;
                        cmd_ok <= 1'b0;
                     end
                     else if (next_sh[7:0] == `OP_RDEXT)
                     begin
                        state <= ST_DOUT;
                     end
                     else if (next_sh[7:0] == `OP_READ)
                     begin
                        state <= quad_command_mode ? ST_SKIP :
                           ST_ADDR;
                     end
                     else if (is_write_cmd(next_sh[7:0]))
                     begin
                        state <= ST_DIN;
                        byte_cnt <= 2'd0;
                     end
                     else if (is_bare_cmd(next_sh[7:0]))
                     begin
                        state <= ST_SKIP;
                     end
                     else
                     begin
                        state <= ST_SKIP;
                        cmd_ok <= 1'b0;
                     end
                  end
               end
               else if (state == ST_ADDR)
               begin
                  if (next_cnt == addr_len)
                  begin
                     mem_addr <= next_addr;
                     mem_rd <= 1'b1;
                     state <= ST_DOUT;
                     out_cnt <= 3'd0;
                     if (address_width_select)
                     begin
                        upper_address_byte <= next_sh[31:24];
                     end
                  end
               end
               else if (state == ST_DIN)
               begin
                  if (next_cnt == `CNT_BYTE)
                  begin
                     cnt <= 6'd0;
                     if (byte_cnt == 2'd0)
                        data0 <= next_sh[7:0];
                     else if (byte_cnt == 2'd1)
                        data1 <= next_sh[7:0];
                     if (byte_cnt != 2'd2)
                        byte_cnt <= byte_cnt + 2'd1;
                  end
               end
            end
            else if (sck_fall && (state == ST_DOUT))
            begin
               // new byte at each boundary: status repeats, data streams
               out_cnt <= out_cnt + step[2:0];
               if (quad_command_mode)
               begin
                  io_out <= out_byte[7:4];
                  io_oe_n <= 4'h0;
                  out_sh <= {out_byte[3:0], 4'h0};
               end
               else
               begin
                  io_out <= {2'b00, out_byte[7], 1'b0};
                  io_oe_n <= 4'hd;
                  out_sh <= {out_byte[6:0], 1'b0};
               end
               if ((out_cnt == 3'd0) && (cmd == `OP_READ))
               begin
                  mem_addr <= mem_addr + 32'd1;
                  mem_rd <= 1'b1;
               end
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // opcode classes
   // ---------------------------------------------------------------
   function is_status_cmd;
      input [7:0] op;
      begin
         is_status_cmd = (op == `OP_RDS1) || (op == `OP_RDS2) ||
            (op == `OP_RDS3);
      end
   endfunction

   function is_write_cmd;
      input [7:0] op;
      begin
         is_write_cmd = (op == `OP_WRS1) || (op == `OP_WRS2) ||
            (op == `OP_WRS3) || (op == `OP_WREXT);
      end
   endfunction

   function is_bare_cmd;
      input [7:0] op;
      begin
         is_bare_cmd = (op == `OP_WREN) || (op == `OP_WRDI) ||
            (op == `OP_VWREN) || (op == `OP_EN4B) || (op == `OP_EX4B);
      end
   endfunction

endmodule // flash_status_addr_cmds

//--- design/sync_2ff.v
// two flip-flop synchroniser for a bundle of asynchronous levels.
// assumes independent level bits.
`timescale 1ns/1ps

module sync_2ff #(
   parameter WIDTH = 1
) (
   input wire ref_clk,
   input wire arst_n,
   input wire [WIDTH-1:0] d,
   output reg [WIDTH-1:0] q
);

   reg [WIDTH-1:0] meta;

   // ---------------------------------------------------------------
   // capture stages
   // ---------------------------------------------------------------
   // meta feeds only the second stage
   always @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta <= {WIDTH{1'b1}};
         q <= {WIDTH{1'b1}};
      end
      else
      begin
         meta <= d;
         q <= meta;
      end
   end

endmodule // sync_2ff

//--- test/flash_status_addr_cmds_sva.sv
// port checks for the flash command block.
// assumes one ref_clk domain.
`timescale 1ns/1ps
`include "flash_cmd_defs.vh"
module flash_status_addr_cmds_sva #(
   parameter [31:0] STATUS_WRITE_CYCLES = 32'd20
) (
   input wire ref_clk,
   input wire arst_n,
   input wire chip_select_n,
   input wire quad_command_mode,
   input wire array_busy,
   input wire [3:0] io_oe_n,
   input wire mem_rd,
   input wire status_write_busy,
   input wire write_enable_latch,
   input wire [7:0] status_two_cfg
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   reg [31:0] busy_cnt;
   // busy period length
   always @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
         busy_cnt <= 32'h0;
      else
         busy_cnt <= status_write_busy ? busy_cnt + 32'h1 : 32'h0;
   end
   // ----------------------------------------------------------
   // checks
   // ----------------------------------------------------------
   oe_idle_a:
      assert property (chip_select_n [*5] |-> io_oe_n == 4'hf)
      else $error("oe while deselected");
   single_pin_a:
      assert property (!quad_command_mode && io_oe_n != 4'hf |->
         io_oe_n == 4'hd) else $error("bad single oe");
   quad_pins_a:
      assert property (quad_command_mode && io_oe_n != 4'hf |->
         io_oe_n == 4'h0) else $error("bad quad oe");
   busy_len_a:
      assert property ($fell(status_write_busy) |->
         busy_cnt == STATUS_WRITE_CYCLES) else $error("busy length");
   wel_end_a:
      assert property ($fell(status_write_busy) |-> ##[0:1]
         !write_enable_latch) else $error("latch kept");
   busy_read_a:
      assert property (status_write_busy || array_busy |-> !mem_rd)
      else $error("read while busy");
   quad_read_a:
      assert property (quad_command_mode |-> !mem_rd)
      else $error("read in quad");
   lock_keep_a:
      assert property ((~status_two_cfg & $past(status_two_cfg) &
         `S2_LB_MASK) == 8'h00) else $error("lock bit cleared");
   qe_hold_a:
      assert property (quad_command_mode && $past(quad_command_mode) |->
         ((status_two_cfg ^ $past(status_two_cfg)) & `S2_QE_MASK) == 8'h00)
      else $error("qe changed in quad");
   rd_pulse_a:
      assert property (mem_rd |=> !mem_rd) else $error("long read pulse");
   cover property ($rose(status_write_busy));
   cover property (mem_rd);
   cover property (quad_command_mode && io_oe_n == 4'h0);
endmodule // flash_status_addr_cmds_sva

//--- test/spi_host_model.sv
// spi host model, mode 0, one or four bits per clock.
// assumes calls only while idle.
`timescale 1ns/1ps
module spi_host_model (
   input wire ref_clk,
   input wire [3:0] io_out,
   output logic chip_select_n,
   output logic serial_clock,
   output logic [3:0] io_in
);
   localparam int HALF = 4;
   logic [63:0] rx_last;
   event rx_ev;
   // idle: clock low, select high
   initial
   begin
      chip_select_n = 1'b1;
      serial_clock = 1'b0;
      io_in = 4'h0;
   end
   // ----------------------------------------------------------
   // one frame: ntx clocks out, nrx in
   // ----------------------------------------------------------
   task automatic xfer(input logic [63:0] tx, input int ntx, nrx, w);
      logic [63:0] rx;
      logic [3:0] nib;
      rx = 64'h0;
      @(negedge ref_clk);
      chip_select_n = 1'b0;
      for (int i = 0; i < ntx + nrx; i++)
      begin
         // idle lines toggle to expose stale sampling
         nib = 4'(tx >> ((ntx - 1 - i) * w));
         if (i >= ntx)
            io_in = ~io_in;
         else
            io_in = w == 4 ? nib : {~io_in[3:1], nib[0]};
         repeat (HALF) @(negedge ref_clk);
         serial_clock = 1'b1;
         if (i >= ntx)
            rx = (rx << w) | {60'h0, w == 4 ? io_out : {3'h0, io_out[1]}};
         repeat (HALF) @(negedge ref_clk);
         serial_clock = 1'b0;
      end
      repeat (HALF) @(negedge ref_clk);
      chip_select_n = 1'b1;
      repeat (2 * HALF) @(negedge ref_clk);
      if (nrx > 0)
      begin
         rx_last = rx;
         ->rx_ev;
      end
   endtask
endmodule // spi_host_model

//--- test/test_flash_status_addr_cmds.sv
// bench for the flash status/address command block.
// assumes spi_host_model and a synthetic array.
`timescale 1ns/1ps
`include "flash_cmd_defs.vh"
module test_flash_status_addr_cmds;
   localparam [31:0] SWC = 32'd200;
   logic ref_clk, arst_n, soft_reset, quad_command_mode, array_busy;
   logic [7:0] mem_rdata, s1, s2, s3, n2, ext, r;
   logic [31:0] a;
   logic [63:0] exp_q[$];
   int error_cnt, comparisons, w;
   wire chip_select_n, serial_clock, mem_rd, status_write_busy;
   wire write_enable_latch, address_width_select;
   wire [3:0] io_in, io_out, io_oe_n;
   wire [31:0] mem_addr;
   wire [7:0] status_one_cfg, status_two_cfg, status_three_cfg;
   wire [7:0] upper_address_byte;
   wire [39:0] regs = {status_one_cfg, status_two_cfg, status_three_cfg,
      upper_address_byte, 5'h0, address_width_select, write_enable_latch,
      status_write_busy};
   flash_status_addr_cmds #(.STATUS_WRITE_CYCLES(SWC))
      u_flash_status_addr_cmds (.ref_clk, .arst_n, .soft_reset,
      .chip_select_n, .serial_clock, .io_in, .io_out, .io_oe_n,
      .quad_command_mode, .array_busy, .mem_addr, .mem_rd, .mem_rdata,
      .status_write_busy, .write_enable_latch, .address_width_select,
      .status_one_cfg, .status_two_cfg, .status_three_cfg,
      .upper_address_byte);
   spi_host_model u_host (.ref_clk, .io_out, .chip_select_n,
      .serial_clock, .io_in);
   // synthetic array, half a cycle late
   function automatic logic [7:0] mem_of(input logic [31:0] x);
      return x[7:0] ^ x[31:24] ^ 8'h5a;
   endfunction
   always @(negedge ref_clk) mem_rdata <= mem_of(mem_addr);
   task automatic cmp(input logic [63:0] e, g);
      comparisons++;
      if (g !== e)
      begin
         error_cnt++;
         $display("mismatch at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   task automatic chk(input logic [39:0] e);
      cmp(e, regs);
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // note the answer before sending
   task automatic go(input logic [63:0] tx, input int nb, input int nr,
                     input logic [63:0] e);
      if (nr > 0)
         exp_q.push_back(e);
      u_host.xfer(tx, nb * 8 / w, nr * 8 / w, w);
   endtask
   task automatic final_report;
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   // match each read to the oldest note
   initial
   forever
   begin
      @(u_host.rx_ev);
      cmp(exp_q.pop_front(), u_host.rx_last);
   end
   // hang guard
   initial
   begin
      repeat (100000) @(posedge ref_clk);
      error_cnt++;
      final_report;
   end
   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial
   begin
      {arst_n, soft_reset, quad_command_mode, array_busy} = 4'h0;
      mem_rdata = 8'h00;
      w = 1;
      void'($urandom(83256));
      idle(12);
      arst_n = 1'b1;
      idle(4);
      chk(40'h0);
      go({`OP_WRS1, 8'hff}, 2, 0, 0);
      chk(40'h0);
      go(`OP_WREN, 1, 0, 0);
      {s1, n2} = 16'($urandom);
      go({`OP_WRS1, s1, n2}, 3, 0, 0);
      s1 &= `S1_WR_MASK;
      n2 &= `S2_WR_MASK;
      s2 = n2;
      go(`OP_RDS1, 1, 1, {s1[7:2], 2'b11});
      idle(SWC);
      chk({s1, s2, 24'h0});
      r = $urandom;
      go(`OP_VWREN, 1, 0, 0);
      go({`OP_WRS3, r}, 2, 0, 0);
      s3 = r & `S3_WR_MASK;
      go(`OP_VWREN, 1, 0, 0);
      go({`OP_WRS2, 8'h00}, 2, 0, 0);
      s2 &= `S2_LB_MASK | `S2_SRP_ONE_PROTECT_MASK;
      chk({s1, s2, s3, 16'h0});
      for (int i = 0; i < 3; i++)
      begin
         r = i == 0 ? s1 : i == 1 ? s2 : s3;
         go(i == 0 ? `OP_RDS1 : i == 1 ? `OP_RDS2 : `OP_RDS3, 1, 2,
            {r, r});
      end
      go(`OP_WREN, 1, 0, 0);
      r = $urandom;
      go({`OP_WRS1, r}, 2, 0, 0);
      s1 = r & `S1_WR_MASK;
      idle(SWC);
      chk({s1, s2, s3, 16'h0});
      r = $urandom;
      go(`OP_WREN, 1, 0, 0);
      go({`OP_WREXT, r}, 2, 0, 0);
      go({`OP_WREXT, ~r}, 2, 0, 0);
      ext = r;
      go(`OP_RDEXT, 1, 1, ext);
      a = {ext, 24'($urandom)};
      go({`OP_READ, a[23:0]}, 4, 2, {mem_of(a), mem_of(a + 1)});
      go(`OP_EN4B, 1, 0, 0);
      a = $urandom;
      go({`OP_READ, a}, 5, 1, mem_of(a));
      ext = a[31:24];
      go(`OP_RDEXT, 1, 1, ext);
      chk({s1, s2, s3, ext, 8'h04});
      go(`OP_EX4B, 1, 0, 0);
      chk({s1, s2, s3, ext, 8'h00});
      soft_reset = 1'b1;
      idle(1);
      soft_reset = 1'b0;
      idle(2);
      chk({s1, n2, 24'h0});
      array_busy = 1'b1;
      go({`OP_READ, a[23:0]}, 4, 0, 0);
      go(`OP_RDS1, 1, 1, {s1[7:2], 2'b01});
      array_busy = 1'b0;
      quad_command_mode = 1'b1;
      w = 4;
      idle(4);
      go(`OP_RDS2, 1, 1, n2);
      go(`OP_VWREN, 1, 0, 0);
      go({`OP_WRS2, n2 ^ `S2_QE_MASK}, 2, 0, 0);
      go({`OP_READ, a[23:0]}, 4, 0, 0);
      chk({s1, n2, 24'h0});
      final_report;
   end
endmodule // test_flash_status_addr_cmds
bind flash_status_addr_cmds flash_status_addr_cmds_sva #(
   .STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES)) u_sva (.ref_clk, .arst_n,
   .chip_select_n, .quad_command_mode, .array_busy, .io_oe_n, .mem_rd,
   .status_write_busy, .write_enable_latch, .status_two_cfg);
